// [logic/fpi_pkg.sv]
`default_nettype none
package fpi_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [4:0]  OFF_CTRL   = 5'h00;
  localparam logic [4:0]  OFF_FLAG   = 5'h04;
  localparam logic [4:0]  OFF_IEN    = 5'h08;
  localparam logic [4:0]  OFF_SW     = 5'h0C;
  localparam logic [4:0]  OFF_STAT   = 5'h10;
  localparam logic [4:0]  OFF_PC     = 5'h14;
  // Control bits
  localparam int          CTL_MODE   = 0;
  localparam int          CTL_EDGE   = 1;
  localparam int          CTL_PINEN  = 2;
  localparam int          CTL_FVEN   = 3;
  localparam int          CTL_OFEN   = 4;
  localparam int          CTL_HF     = 5;
  localparam int          CTL_XT2    = 6;
  // Flag bits
  localparam int          FLG_PIN    = 0;
  localparam int          FLG_FV     = 1;
  localparam int          FLG_OF     = 2;
  localparam int          FLG_WDT    = 3;
  // Status word global enable bit
  localparam int          SW_GIE     = 3;
  // Reset values
  localparam logic [6:0]  CTRL_RST   = 7'h00;
  localparam logic [3:0]  FLAG_RST   = 4'h4;
  localparam logic [13:0] IEN_RST    = 14'h0000;
  localparam logic [15:0] SW_RST     = 16'h0000;
  // Vector table and priorities
  localparam int          NUM_PERIPH = 14;
  localparam logic [15:0] VEC_BASE   = 16'hFFE0;
  localparam logic [3:0]  PRI_RESET  = 4'hF;
  localparam logic [3:0]  PRI_NMI    = 4'hE;
  localparam logic [3:0]  PRI_WDT    = 4'hA;
  // Sequence lengths in cycles
  localparam logic [2:0]  ENTRY_CYC  = 3'h6;
  localparam logic [2:0]  RETURN_CYC = 3'h5;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_HOLD   = 4'b0001,
    ST_IDLE   = 4'b0010,
    ST_ENTRY  = 4'b0100,
    ST_RETURN = 4'b1000
  } fpi_state_t;
endpackage : fpi_pkg
`default_nettype wire

// [logic/fpi_unit.sv]
// Summary of operation
// - Chain position fixes priority; nearer wins.
// - NMI ignores global enable, own enables only.
// - Accepting NMI clears all three NMI enables.
// - NMI sources share vector FFFC, priority 14.
// - NMI sources: pin edge, osc fault, flash.
// - Pin low holds reset; high starts FFFE.
// - Selected edge sets flag; enable gates NMI.
// - Power-up clear returns pin to reset function.
// - Edge-select change fires only in NMI mode.
// - Flash violation sets flag, enable gates NMI.
// - Oscillator fault sets flag, enable gates NMI.
// - Power-up clear forces LF, second crystal off.
// - Maskable needs own enable and global enable.
// - Watchdog interval overflow: vector FFF4, prio 10.
// - Entry takes six cycles to handler start.
// - Finish instruction, push next PC, then status.
// - Highest pending priority is served first.
// - Single-source flag cleared on acceptance.
// - Clear status word, then load vector into PC.
// - Return: five cycles, pop status then PC.
// - Sixteen vectors FFE0-FFFF, priority 0 to 15.
`timescale 1ns/1ps
`default_nettype none
module fpi_unit (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        rst_nmi_pin_i,
  input  wire logic        osc_fault_i,
  input  wire logic        flash_viol_i,
  input  wire logic        wdt_overflow_i,
  input  wire logic        wdt_interval_i,
  input  wire logic [13:0] periph_req_i,
  input  wire logic        instr_done_i,
  input  wire logic [15:0] next_pc_i,
  input  wire logic        return_from_irq_i,
  input  wire logic [15:0] pop_data_i,
  input  wire logic [15:0] vec_data_i,
  output logic             cpu_reset_o,
  output logic             push_o,
  output logic      [15:0] push_data_o,
  output logic             pop_o,
  output logic             vec_rd_o,
  output logic      [15:0] vec_addr_o,
  output logic             handler_start_o,
  output logic             resume_o,
  output logic      [13:0] irq_ack_o,
  output logic      [15:0] pc_o,
  output logic      [15:0] status_word_o,
  output logic             hf_mode_o,
  output logic             second_crystal_on_o
);

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    fpi_pkg::fpi_state_t state;
    logic [2:0]          cnt;
    logic [3:0]          vec;
    logic [6:0]          ctrl;
    logic [3:0]          flags;
    logic [13:0]         ien;
    logic [15:0]         sw;
    logic [15:0]         pc;
    logic [15:0]         out_data;
    logic                pin_s1;
    logic                pin_s2;
    logic                trig_prev;
    logic                osc_s1;
    logic                osc_s2;
    logic                ack;
    logic [31:0]         rdata;
  } fpi_regs_t;
  fpi_regs_t r_q;
  fpi_regs_t r_d;

  // ****************************************
  // Helper functions
  // ****************************************
  // Byte-lane merge of a bus write
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge
  // Highest set bit of the chain, position is priority
  // chain position priority
  function automatic logic [3:0] pri_enc(input logic [13:0] req);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < fpi_pkg::NUM_PERIPH; i++) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : pri_enc
  // One-hot line for a maskable priority
  function automatic logic [13:0] line_of(input logic [3:0] pri);
    logic [13:0] oh;
    oh = 14'h0000;
    if (pri < 4'(fpi_pkg::NUM_PERIPH)) begin
      oh[pri] = 1'b1;
    end
    return oh;
  endfunction : line_of

  // ****************************************
  // Combinational terms
  // ****************************************
  logic        trig;
  logic        pin_edge;
  logic        nmi_req;
  logic [13:0] mask_req;
  logic        any_req;
  logic [3:0]  sel;
  logic        bus_req;
  logic        bus_take;
  logic        in_entry;
  logic        in_return;
  logic [31:0] wmerged;

  // Edge detection on the selected polarity
  // edge select
  assign trig      = r_q.ctrl[fpi_pkg::CTL_EDGE] ? ~r_q.pin_s2 : r_q.pin_s2;
  assign pin_edge  = r_q.ctrl[fpi_pkg::CTL_MODE] & trig & ~r_q.trig_prev;
  // Request gating
  // NMI gating
  assign nmi_req   = (r_q.flags[fpi_pkg::FLG_PIN] & r_q.ctrl[fpi_pkg::CTL_PINEN])
                   | (r_q.flags[fpi_pkg::FLG_FV] & r_q.ctrl[fpi_pkg::CTL_FVEN])
                   | (r_q.flags[fpi_pkg::FLG_OF] & r_q.ctrl[fpi_pkg::CTL_OFEN]);
  assign mask_req  = (periph_req_i | line_of(fpi_pkg::PRI_WDT)
                      & {14{r_q.flags[fpi_pkg::FLG_WDT]}})
                   & r_q.ien & {14{r_q.sw[fpi_pkg::SW_GIE]}};
  assign any_req   = nmi_req | (|mask_req);
  assign sel       = nmi_req ? fpi_pkg::PRI_NMI : pri_enc(mask_req);
  assign bus_req   = avs_read_i | avs_write_i;
  assign bus_take  = bus_req & ~r_q.ack;
  assign in_entry  = r_q.state == fpi_pkg::ST_ENTRY;
  assign in_return = r_q.state == fpi_pkg::ST_RETURN;
  assign wmerged   = be_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [31:0] cur;
    cur = 32'h0000_0000;
    r_d = r_q;
    // Pin and oscillator synchronisers
    r_d.pin_s1    = rst_nmi_pin_i;
    r_d.pin_s2    = r_q.pin_s1;
    r_d.osc_s1    = osc_fault_i;
    r_d.osc_s2    = r_q.osc_s1;
    r_d.trig_prev = trig;
    // Bus access, one wait cycle then answer
    r_d.ack = bus_take;
    if (bus_take) begin
      case (avs_address_i)
        fpi_pkg::OFF_CTRL: cur = {25'h000_0000, r_q.ctrl};
        fpi_pkg::OFF_FLAG: cur = {28'h000_0000, r_q.flags};
        fpi_pkg::OFF_IEN:  cur = {18'h0_0000, r_q.ien};
        fpi_pkg::OFF_SW:   cur = {16'h0000, r_q.sw};
        fpi_pkg::OFF_STAT: cur = {21'h00_0000, r_q.state, r_q.cnt, r_q.vec};
        fpi_pkg::OFF_PC:   cur = {16'h0000, r_q.pc};
        default:           cur = 32'h0000_0000;
      endcase
      r_d.rdata = cur;
      if (avs_write_i) begin
        cur = be_merge(cur, avs_writedata_i, avs_byteenable_i);
        case (avs_address_i)
          fpi_pkg::OFF_CTRL: r_d.ctrl  = cur[6:0];
          fpi_pkg::OFF_FLAG: r_d.flags = r_q.flags & ~wmerged[3:0];
          fpi_pkg::OFF_IEN:  r_d.ien   = cur[13:0];
          fpi_pkg::OFF_SW:   r_d.sw    = cur[15:0];
          default: ;
        endcase
      end
    end
    // Flag sources, a set wins over a clear
    // pin flag
    if (pin_edge) r_d.flags[fpi_pkg::FLG_PIN] = 1'b1;
    if (flash_viol_i) r_d.flags[fpi_pkg::FLG_FV] = 1'b1;
    if (r_q.osc_s2) r_d.flags[fpi_pkg::FLG_OF] = 1'b1;
    if (wdt_overflow_i & wdt_interval_i) begin
      r_d.flags[fpi_pkg::FLG_WDT] = 1'b1;
    end
    // Sequencer
    case (r_q.state)
      fpi_pkg::ST_HOLD: begin
        if (r_q.pin_s2) begin
          r_d.state = fpi_pkg::ST_ENTRY;
          r_d.vec   = fpi_pkg::PRI_RESET;
          r_d.cnt   = 3'h3;
        end
      end
      fpi_pkg::ST_IDLE: begin
        if (return_from_irq_i) begin
          r_d.state = fpi_pkg::ST_RETURN;
          r_d.cnt   = 3'h1;
        end else if (instr_done_i & any_req) begin
          r_d.state    = fpi_pkg::ST_ENTRY;
          r_d.cnt      = 3'h1;
          r_d.vec      = sel;
          r_d.out_data = next_pc_i;
          if (nmi_req) begin
            r_d.ctrl[fpi_pkg::CTL_PINEN] = 1'b0;
            r_d.ctrl[fpi_pkg::CTL_FVEN]  = 1'b0;
            r_d.ctrl[fpi_pkg::CTL_OFEN]  = 1'b0;
          end
        end
      end
      fpi_pkg::ST_ENTRY: begin
        r_d.cnt = r_q.cnt + 3'h1;
        if (r_q.cnt == 3'h1) r_d.out_data = r_q.sw;
        if (r_q.cnt == 3'h3) begin
          r_d.sw = fpi_pkg::SW_RST;
          if (r_q.vec == fpi_pkg::PRI_WDT &&
              !(wdt_overflow_i & wdt_interval_i)) begin
            r_d.flags[fpi_pkg::FLG_WDT] = 1'b0;
          end
        end
        if (r_q.cnt == 3'h4) r_d.pc = vec_data_i;
        if (r_q.cnt == fpi_pkg::ENTRY_CYC) begin
          r_d.state = fpi_pkg::ST_IDLE;
          r_d.cnt   = 3'h0;
        end
      end
      fpi_pkg::ST_RETURN: begin
        r_d.cnt = r_q.cnt + 3'h1;
        if (r_q.cnt == 3'h1) r_d.sw = pop_data_i;
        if (r_q.cnt == 3'h2) r_d.pc = pop_data_i;
        if (r_q.cnt == fpi_pkg::RETURN_CYC) begin
          r_d.state = fpi_pkg::ST_IDLE;
          r_d.cnt   = 3'h0;
        end
      end
      default: begin
        r_d.state = fpi_pkg::ST_HOLD;
        r_d.cnt   = 3'h0;
      end
    endcase
    // Pin low in reset function holds the CPU
    // reset function
    if (!r_q.ctrl[fpi_pkg::CTL_MODE] && !r_q.pin_s2) begin
      r_d.state = fpi_pkg::ST_HOLD;
      r_d.cnt   = 3'h0;
    end
  end
  // State register, synchronous reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      r_q       <= '0;
      r_q.state <= fpi_pkg::ST_HOLD;
      r_q.ctrl  <= fpi_pkg::CTRL_RST;
      r_q.flags <= fpi_pkg::FLAG_RST;
      r_q.ien   <= fpi_pkg::IEN_RST;
      r_q.sw    <= fpi_pkg::SW_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // vector address
  assign vec_addr_o          = fpi_pkg::VEC_BASE + {11'h000, r_q.vec, 1'b0};
  assign push_o              = in_entry & (r_q.cnt == 3'h1 || r_q.cnt == 3'h2);
  assign push_data_o         = r_q.out_data;
  assign pop_o               = in_return & (r_q.cnt == 3'h1 || r_q.cnt == 3'h2);
  assign vec_rd_o            = in_entry & (r_q.cnt == 3'h3);
  assign handler_start_o     = in_entry & (r_q.cnt == fpi_pkg::ENTRY_CYC);
  assign resume_o            = in_return & (r_q.cnt == fpi_pkg::RETURN_CYC);
  assign irq_ack_o           = vec_rd_o ? line_of(r_q.vec) : 14'h0000;
  assign cpu_reset_o         = r_q.state == fpi_pkg::ST_HOLD;
  assign pc_o                = r_q.pc;
  assign status_word_o       = r_q.sw;
  assign hf_mode_o           = r_q.ctrl[fpi_pkg::CTL_HF];
  assign second_crystal_on_o = r_q.ctrl[fpi_pkg::CTL_XT2];
  assign avs_readdata_o      = r_q.rdata;
  assign avs_waitrequest_o   = bus_req & ~r_q.ack;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_accept;
    r_q.state == fpi_pkg::ST_IDLE && !return_from_irq_i && instr_done_i && any_req;
  endsequence
  sequence s_stack;
    push_o ##1 push_o ##1 vec_rd_o;
  endsequence
  sequence s_pops;
    pop_o ##1 pop_o ##1 !pop_o [*2] ##1 resume_o;
  endsequence
  entry_six_a: assert property (s_accept |-> ##6 handler_start_o)
    else $error("handler start not six cycles after accept");
  push_order_a: assert property (s_accept |=> s_stack)
    else $error("push and vector order wrong");
  push_pc_a: assert property (s_accept |=> push_data_o == $past(next_pc_i))
    else $error("first push is not the next pc");
  nmi_disarm_a: assert property ((s_accept and nmi_req) |=>
      !r_q.ctrl[fpi_pkg::CTL_PINEN] && !r_q.ctrl[fpi_pkg::CTL_FVEN]
      && !r_q.ctrl[fpi_pkg::CTL_OFEN])
    else $error("nmi enables not cleared");
  nmi_vector_a: assert property ((s_accept and nmi_req) |-> ##3
      vec_addr_o == 16'hFFFC)
    else $error("nmi vector address wrong");
  mask_gie_a: assert property (!r_q.sw[fpi_pkg::SW_GIE] && !nmi_req
      && instr_done_i && r_q.state == fpi_pkg::ST_IDLE |=> !in_entry)
    else $error("maskable taken with global enable off");
  sw_clear_a: assert property (vec_rd_o |=> status_word_o == 16'h0000)
    else $error("status word not cleared");
  pc_load_a: assert property (vec_rd_o ##1 1'b1 |=> pc_o == $past(vec_data_i))
    else $error("vector not loaded into pc");
  return_five_a: assert property (r_q.state == fpi_pkg::ST_IDLE && return_from_irq_i
      |=> s_pops)
    else $error("return sequence wrong");
  pin_hold_a: assert property (!r_q.ctrl[fpi_pkg::CTL_MODE] && !r_q.pin_s2
      |=> cpu_reset_o)
    else $error("cpu not held in reset");
  pin_flag_a: assert property (pin_edge |=> r_q.flags[fpi_pkg::FLG_PIN])
    else $error("pin flag not set by edge");
  wdt_clear_a: assert property (vec_rd_o && r_q.vec == fpi_pkg::PRI_WDT
      && !(wdt_overflow_i & wdt_interval_i) |=> !r_q.flags[fpi_pkg::FLG_WDT])
    else $error("watchdog flag not cleared");

endmodule : fpi_unit
`default_nettype wire

// [bench/fpi_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fpi_cpu_model (
  input  wire logic        mclk_i,
  input  wire logic        push_i,
  input  wire logic [15:0] push_data_i,
  input  wire logic        pop_i,
  input  wire logic        vec_rd_i,
  input  wire logic [15:0] vec_addr_i,
  output var  logic [15:0] pop_data_o,
  output var  logic [15:0] vec_data_o
);
  logic [15:0] stk_q [0:31];
  logic [4:0]  sp_q   = 5'h00;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] vec_q  = 16'h0000;
  // ****************************************
  // Stack and vector memory
  // ****************************************
  // stack word order
  always @(posedge mclk_i) begin
    if (push_i) begin
      stk_q[sp_q] <= push_data_i;
      sp_q        <= sp_q + 5'h01;
    end else if (pop_i) begin
      sp_q <= sp_q - 5'h01;
    end
    if (pop_i) begin
      last_q <= pop_data_o;
    end
    // Vector word is the inverted address, a moving pattern otherwise
    vec_q <= vec_rd_i ? ~vec_addr_i : ~vec_q;
  end
  // Popped word is only valid while popping
  assign pop_data_o = pop_i ? stk_q[sp_q - 5'h01] : ~last_q;
  assign vec_data_o = vec_q;
endmodule : fpi_cpu_model
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk  = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr  = 5'h00;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        pin   = 1'b0;
  logic        osc   = 1'b0;
  logic        fv    = 1'b0;
  logic        wov   = 1'b0;
  logic        wint  = 1'b0;
  logic [13:0] preq  = 14'h0000;
  logic        idone = 1'b0;
  logic [15:0] npc   = 16'h0000;
  logic        return_from_irq  = 1'b0;
  logic [31:0] rdata;
  logic        wreq, cpu_reset, push, pop, vec_rd, hstart, resume, hf, xt2;
  logic [15:0] pop_data, vec_data, push_data, vec_addr, pc, sw, last_vec;
  logic [13:0] ack, last_ack;
  int          n_fail    = 0;
  int          cmp_count = 0;
  // Clock generator, 100 MHz
  always #5 mclk = ~mclk;
  fpi_unit dut_u (.mclk_i(mclk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .rst_nmi_pin_i(pin), .osc_fault_i(osc),
    .flash_viol_i(fv), .wdt_overflow_i(wov), .wdt_interval_i(wint),
    .periph_req_i(preq), .instr_done_i(idone), .next_pc_i(npc),
    .return_from_irq_i(return_from_irq), .pop_data_i(pop_data), .vec_data_i(vec_data),
    .cpu_reset_o(cpu_reset), .push_o(push), .push_data_o(push_data),
    .pop_o(pop), .vec_rd_o(vec_rd), .vec_addr_o(vec_addr),
    .handler_start_o(hstart), .resume_o(resume), .irq_ack_o(ack),
    .pc_o(pc), .status_word_o(sw), .hf_mode_o(hf),
    .second_crystal_on_o(xt2));
  fpi_cpu_model cpu_u (.mclk_i(mclk), .push_i(push), .push_data_i(push_data),
    .pop_i(pop), .vec_rd_i(vec_rd), .vec_addr_i(vec_addr),
    .pop_data_o(pop_data), .vec_data_o(vec_data));
  // Capture vector address and acknowledge of each fetch
  always @(posedge mclk) begin
    if (vec_rd) begin
      last_vec <= vec_addr;
      last_ack <= ack;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // Avalon transfer held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wrr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrr
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rd_chk
  // Entry (r=0) or return (r=1); n is cycles to completion, 99 if none
  task automatic step(input logic r, input logic [15:0] np, output int n);
    n = 0;
    @(posedge mclk);
    return_from_irq  <= r;
    idone <= !r;
    npc   <= np;
    do begin
      @(posedge mclk);
      return_from_irq  <= 1'b0;
      idone <= 1'b0;
      n++;
      #1;
    end while ((r ? resume : hstart) !== 1'b1 && n < 12);
    if (n >= 12) n = 99;
  endtask : step
  task automatic boot;
    int n;
    n = 0;
    @(posedge mclk);
    pin <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      #1;
    end while (hstart !== 1'b1 && n < 30);
    chk(last_vec, 16'hFFFE);
    chk(pc, 16'h0001);
    chk(cpu_reset, 1'b0);
  endtask : boot
  task automatic pulse_pin;
    @(posedge mclk);
    pin <= 1'b0;
    repeat (5) @(posedge mclk);
    pin <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask : pulse_pin
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    int n;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk(cpu_reset, 1'b1);
    boot();
    rd_chk(fpi_pkg::OFF_CTRL, 32'h0000_0000);
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0004);
    rd_chk(5'h18, 32'h0000_0000);
    $display("test reset finished");
    wrr(fpi_pkg::OFF_FLAG, 32'h0000_000F);
    @(posedge mclk);
    fv <= 1'b1;
    @(posedge mclk);
    fv <= 1'b0;
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0002);
    step(1'b0, 16'h1234, n);
    chk(n, 99);
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_0008);
    step(1'b0, 16'h1234, n);
    chk(n, 6);
    chk(last_vec, 16'hFFFC);
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0002);
    $display("test flash violation finished");
    wrr(fpi_pkg::OFF_FLAG, 32'h0000_000F);
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_001C);
    @(posedge mclk);
    osc <= 1'b1;
    repeat (4) @(posedge mclk);
    step(1'b0, 16'h1111, n);
    chk(last_vec, 16'hFFFC);
    rd_chk(fpi_pkg::OFF_CTRL, 32'h0000_0000);
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0004);
    @(posedge mclk);
    osc <= 1'b0;
    repeat (4) @(posedge mclk);
    $display("test oscillator fault finished");
    wrr(fpi_pkg::OFF_FLAG, 32'h0000_000F);
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_0002);
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_0000);
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0000);
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_0001);
    wrr(fpi_pkg::OFF_FLAG, 32'h0000_000F);
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_0005);
    pulse_pin();
    chk(cpu_reset, 1'b0);
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0001);
    step(1'b0, 16'h2222, n);
    chk(last_vec, 16'hFFFC);
    wrr(fpi_pkg::OFF_FLAG, 32'h0000_000F);
    pulse_pin();
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0001);
    step(1'b0, 16'h2222, n);
    chk(n, 99);
    wrr(fpi_pkg::OFF_FLAG, 32'h0000_000F);
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_0003);
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_0001);
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0001);
    wrr(fpi_pkg::OFF_FLAG, 32'h0000_000F);
    $display("test pin event finished");
    wrr(fpi_pkg::OFF_IEN, 32'h0000_0020);
    preq <= 14'h0020;
    step(1'b0, 16'h2468, n);
    chk(n, 99);
    wrr(fpi_pkg::OFF_SW, 32'h0000_0008);
    step(1'b0, 16'h2468, n);
    chk(n, 6);
    chk(last_vec, 16'hFFEA);
    chk(last_ack, 14'h0020);
    chk(pc, 16'h0015);
    chk(sw, 16'h0000);
    chk(cpu_u.stk_q[cpu_u.sp_q - 5'h02], 16'h2468);
    chk(cpu_u.stk_q[cpu_u.sp_q - 5'h01], 16'h0008);
    @(posedge mclk);
    preq <= 14'h0000;
    step(1'b1, 16'h0000, n);
    chk(n, 5);
    chk(pc, 16'h2468);
    chk(sw, 16'h0008);
    $display("test maskable entry finished");
    @(posedge mclk);
    preq <= 14'h0208;
    step(1'b0, 16'h3000, n);
    chk(n, 99);
    wrr(fpi_pkg::OFF_IEN, 32'h0000_0208);
    step(1'b0, 16'h3000, n);
    chk(last_vec, 16'hFFF2);
    chk(last_ack, 14'h0200);
    @(posedge mclk);
    preq <= 14'h0000;
    step(1'b1, 16'h0000, n);
    $display("test priority finished");
    wrr(fpi_pkg::OFF_IEN, 32'h0000_0400);
    wint <= 1'b1;
    @(posedge mclk);
    wov <= 1'b1;
    @(posedge mclk);
    wov <= 1'b0;
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0008);
    step(1'b0, 16'h4000, n);
    chk(last_vec, 16'hFFF4);
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0000);
    step(1'b1, 16'h0000, n);
    $display("test watchdog finished");
    wrr(fpi_pkg::OFF_CTRL, 32'h0000_0061);
    #1;
    chk({hf, xt2}, 2'b11);
    @(posedge mclk);
    pin <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk(cpu_reset, 1'b1);
    chk({hf, xt2}, 2'b00);
    rd_chk(fpi_pkg::OFF_FLAG, 32'h0000_0004);
    boot();
    $display("test power-up clear finished");
    test_done();
  end
  // Watchdog against a hung design
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
